// file: core/wesc_map.vh
// Constants for the wake and enable state control block.
// Assumes a 100 MHz system clock and plain-port register access.
`ifndef WESC_MAP_VH
`define WESC_MAP_VH

// ************************************************************
// Register offsets
// ************************************************************
`define WESC_ADDR_CMD      8'h00
`define WESC_ADDR_STATE    8'h04
`define WESC_ADDR_IRQ_STAT 8'h08
`define WESC_ADDR_IRQ_CLR  8'h0c
`define WESC_ADDR_IRQ_EN   8'h10
`define WESC_ADDR_STRAPS   8'h14

// ************************************************************
// Command codes written to the command register
// ************************************************************
`define WESC_CMD_NORMAL    3'h1
`define WESC_CMD_SLEEP     3'h2
`define WESC_CMD_STANDBY   3'h3
`define WESC_CMD_FAIL_SAFE_STATE  3'h4
`define WESC_CMD_RST_DONE  3'h5

// ************************************************************
// State codes
// ************************************************************
`define WESC_ST_INIT       3'h0
`define WESC_ST_NORMAL     3'h1
`define WESC_ST_TO_SLEEP   3'h2
`define WESC_ST_SLEEP      3'h3
`define WESC_ST_TO_STBY    3'h4
`define WESC_ST_STANDBY    3'h5
`define WESC_ST_WAKE       3'h6
`define WESC_ST_FAIL_SAFE_STATE   3'h7

// ************************************************************
// Interrupt status bit positions
// ************************************************************
`define WESC_IRQ_WAKE_DIV  0
`define WESC_IRQ_WAKE_EVT  1
`define WESC_IRQ_STBY_RST  2
`define WESC_IRQ_BOOST     3
`define WESC_IRQ_W         4

// ************************************************************
// Reset values
// ************************************************************
`define WESC_IRQ_EN_RST    4'h0

// ************************************************************
// Timing
// ************************************************************
`define WESC_CLK_MHZ       100
`define WESC_WAKE_MIN_US   40
`define WESC_WAKE_MIN_CYC  (`WESC_WAKE_MIN_US * `WESC_CLK_MHZ)
`define WESC_TRANS_CYC     16

`endif

// file: core/wesc_ctrl.v
// Wake and enable detection, power state control and pre-regulator
// controls. Assumes all inputs but wake and enable synchronous to clk_sys at 100 MHz.
//
// Notes on behaviour
// - After reset start in initialization state
// - Init to normal only by command
// - Normal or wake commanded to sleep, standby
// - Wake level valid after 40 us high
// - Enable rising edge is a wake event
// - Wake: standby/fail-safe to init, sleep to wake
// - Low wake or falling enable does nothing
// - Wake during sleep entry: wake state, interrupt
// - Wake during standby entry: init, reset out
// - Low-power commands work with enable high
// - Boost off when boost strap grounded
// - Frequency strap open selects high range
// - Buck enable always on
// - Boost runs while input undervoltage reported
// - Pulse-frequency mode allowed only in sleep
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "wesc_map.vh"

module wesc_ctrl #(
  parameter WAKE_MIN_CYC = `WESC_WAKE_MIN_CYC,
  parameter TRANS_CYC    = `WESC_TRANS_CYC
) (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        wake_level_input,
  input  wire        enable_edge_input,
  input  wire        boost_select_strap,
  input  wire        frequency_range_strap,
  input  wire        input_uv,
  input  wire        light_load,
  output reg         reset_output,
  output reg         irq,
  output reg         boost_en,
  output reg         buck_en,
  output reg         buck_freq_high,
  output reg         buck_pfm_en,
  output reg  [2:0]  state
);

  // ************************************************************
  // Decode helpers
  // ************************************************************
  // True when a command write carries the wanted code
  function is_cmd;
    input       wr_hit;
    input [2:0] code;
    input [2:0] want;
    begin
      is_cmd = wr_hit && (code == want);
    end
  endfunction

  // Shared by both low-power entry phases
  function trans_end;
    input [7:0] cnt;
    input [7:0] len;
    begin
      trans_end = (cnt == len - 8'h01);
    end
  endfunction

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Two stages each; only the second stage is read downstream
  reg        wak_s1_r;
  reg        wak_s2_r;
  reg        ena_s1_r;
  reg        ena_s2_r;
  reg        ena_d_r;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wak_s1_r <= 1'b0;
      wak_s2_r <= 1'b0;
      ena_s1_r <= 1'b0;
      ena_s2_r <= 1'b0;
    end else begin
      wak_s1_r <= wake_level_input;
      wak_s2_r <= wak_s1_r;
      ena_s1_r <= enable_edge_input;
      ena_s2_r <= ena_s1_r;
    end
  end

  // ************************************************************
  // Wake level qualification
  // ************************************************************
  reg [13:0] wak_cnt_r;
  reg        wak_done_r;
  reg        wak_evt_r;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wak_cnt_r  <= 14'h0000;
      wak_done_r <= 1'b0;
      wak_evt_r  <= 1'b0;
    end else begin
      wak_evt_r <= 1'b0;
      // Count must be unbroken; a low level only rearms
      if (!wak_s2_r) begin
        wak_cnt_r  <= 14'h0000;
        wak_done_r <= 1'b0;
      end else if (!wak_done_r) begin
        if (wak_cnt_r == WAKE_MIN_CYC[13:0] - 14'h0001) begin
          wak_done_r <= 1'b1;
          wak_evt_r  <= 1'b1;
        end else begin
          wak_cnt_r <= wak_cnt_r + 14'h0001;
        end
      end
    end
  end

  // ************************************************************
  // Enable edge detection
  // ************************************************************
  // Delay flop resets low like the idle pin: no false edge
  reg        ena_evt_r;
  wire       wake_evt;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ena_d_r   <= 1'b0;
      ena_evt_r <= 1'b0;
    end else begin
      ena_d_r <= ena_s2_r;
      // Only the rising edge; falling edge ignored
      ena_evt_r <= ena_s2_r & ~ena_d_r;
    end
  end

  assign wake_evt = wak_evt_r | ena_evt_r;

  // ************************************************************
  // Register access decode
  // ************************************************************
  wire       cmd_wr = reg_wr && (reg_addr == `WESC_ADDR_CMD);
  wire [2:0] cmd    = reg_wdata[2:0];
  wire       clr_wr = reg_wr && (reg_addr == `WESC_ADDR_IRQ_CLR);

  // ************************************************************
  // Power state machine
  // ************************************************************
  localparam [2:0] ST_INIT     = `WESC_ST_INIT;
  localparam [2:0] ST_NORMAL   = `WESC_ST_NORMAL;
  localparam [2:0] ST_TO_SLEEP = `WESC_ST_TO_SLEEP;
  localparam [2:0] ST_SLEEP    = `WESC_ST_SLEEP;
  localparam [2:0] ST_TO_STBY  = `WESC_ST_TO_STBY;
  localparam [2:0] ST_STANDBY  = `WESC_ST_STANDBY;
  localparam [2:0] ST_WAKE     = `WESC_ST_WAKE;
  localparam [2:0] ST_FAIL_SAFE_STATE = `WESC_ST_FAIL_SAFE_STATE;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] trans_cnt_r;
  reg       div_wake;
  reg       div_stby;
  reg       evt_wake;

  always @* begin
    state_nxt = state_r;
    div_wake  = 1'b0;
    div_stby  = 1'b0;
    evt_wake  = 1'b0;
    case (state_r)
      ST_INIT: begin
        if (is_cmd(cmd_wr, cmd, `WESC_CMD_NORMAL)) begin
          state_nxt = ST_NORMAL;
        end else if (is_cmd(cmd_wr, cmd, `WESC_CMD_FAIL_SAFE_STATE)) begin
          state_nxt = ST_FAIL_SAFE_STATE;
        end
      end
      ST_NORMAL, ST_WAKE: begin
        // Enable level is not looked at here
        if (is_cmd(cmd_wr, cmd, `WESC_CMD_SLEEP)) begin
          state_nxt = ST_TO_SLEEP;
        end else if (is_cmd(cmd_wr, cmd, `WESC_CMD_STANDBY)) begin
          state_nxt = ST_TO_STBY;
        end else if (is_cmd(cmd_wr, cmd, `WESC_CMD_FAIL_SAFE_STATE)) begin
          state_nxt = ST_FAIL_SAFE_STATE;
        end
        // Wake events dropped in these states
      end
      // A wake beats the end of the phase in the same cycle
      ST_TO_SLEEP: begin
        if (wake_evt) begin
          state_nxt = ST_WAKE;
          div_wake  = 1'b1;
        end else if (trans_end(trans_cnt_r, TRANS_CYC[7:0])) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_TO_STBY: begin
        if (wake_evt) begin
          state_nxt = ST_INIT;
          div_stby  = 1'b1;
        end else if (trans_end(trans_cnt_r, TRANS_CYC[7:0])) begin
          state_nxt = ST_STANDBY;
        end
      end
      ST_SLEEP: begin
        if (wake_evt) begin
          state_nxt = ST_WAKE;
          evt_wake  = 1'b1;
        end
      end
      ST_STANDBY, ST_FAIL_SAFE_STATE: begin
        if (wake_evt) begin
          state_nxt = ST_INIT;
          evt_wake  = 1'b1;
        end
      end
      default: state_nxt = ST_INIT;
    endcase
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r     <= ST_INIT;
      trans_cnt_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      // Phase timer restarts on every state change
      if (state_nxt != state_r) begin
        trans_cnt_r <= 8'h00;
      end else begin
        trans_cnt_r <= trans_cnt_r + 8'h01;
      end
    end
  end

  // ************************************************************
  // Interrupt status, enable and clear
  // ************************************************************
  reg  [3:0] irq_stat_r;
  reg  [3:0] irq_en_r;
  reg        boost_d_r;
  wire [3:0] irq_set;
  wire       boost_nxt;

  // Boost only when strap open and input low
  assign boost_nxt = boost_select_strap & input_uv;
  assign irq_set   = {boost_nxt & ~boost_d_r, div_stby, evt_wake,
                      div_wake};

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_stat_r <= 4'h0;
      irq_en_r   <= `WESC_IRQ_EN_RST;
      boost_d_r  <= 1'b0;
    end else begin
      boost_d_r <= boost_nxt;
      // Set beats a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~(clr_wr ? reg_wdata[3:0] : 4'h0))
                    | irq_set;
      if (reg_wr && reg_addr == `WESC_ADDR_IRQ_EN)
        irq_en_r <= reg_wdata[3:0];
    end
  end

  // ************************************************************
  // Reset and interrupt outputs
  // ************************************************************
  // Host reset held until software acknowledges it
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      reset_output <= 1'b1;
    end else if (div_stby) begin
      reset_output <= 1'b1;
    end else if (is_cmd(cmd_wr, cmd, `WESC_CMD_RST_DONE)) begin
      reset_output <= 1'b0;
    end
  end

  // Wake diverted from sleep entry always interrupts the host; standby diversion only when enabled
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat_r | irq_set) & irq_en_r) | div_wake;
    end
  end

  // ************************************************************
  // Pre-regulator controls
  // ************************************************************
  // Straps read every cycle; no latching at power-up
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      boost_en       <= 1'b0;
      buck_en        <= 1'b1;
      buck_freq_high <= 1'b0;
      buck_pfm_en    <= 1'b0;
    end else begin
      boost_en       <= boost_nxt;
      buck_en        <= 1'b1;
      buck_freq_high <= frequency_range_strap;
      buck_pfm_en    <= light_load && state_nxt == ST_SLEEP;
    end
  end

  // ************************************************************
  // State copy and read data
  // ************************************************************
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= ST_INIT;
    end else begin
      state <= state_nxt;
    end
  end

  // Read data stand one cycle, zero otherwise
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `WESC_ADDR_STATE:    reg_rdata <= {29'h0, state_r};
        `WESC_ADDR_IRQ_STAT: reg_rdata <= {28'h0, irq_stat_r};
        `WESC_ADDR_IRQ_EN:   reg_rdata <= {28'h0, irq_en_r};
        `WESC_ADDR_STRAPS:   reg_rdata <= {28'h0, reset_output,
                               boost_en, frequency_range_strap,
                               boost_select_strap};
        default:             reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// file: tb/wesc_ctrl_asserts.sv
// Port checker for the wake and enable state control block.
// Assumes a bind onto wesc_ctrl and one clock, clk_sys.
`timescale 1ns/1ps
`include "wesc_map.vh"
module wesc_ctrl_asserts (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        boost_select_strap,
  input wire logic        frequency_range_strap,
  input wire logic        input_uv,
  input wire logic        reset_output,
  input wire logic        irq,
  input wire logic        boost_en,
  input wire logic        buck_en,
  input wire logic        buck_freq_high,
  input wire logic        buck_pfm_en,
  input wire logic [2:0]  state
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ************************************************************
  // Assertions
  // ************************************************************
  chk_buck_always: assert property (buck_en)
    else $error("buck enable dropped");
  chk_boost_follow: assert property (
    !$past(sys_rst) |->
    boost_en == $past(boost_select_strap & input_uv))
    else $error("boost enable wrong");
  chk_freq_follow: assert property (
    !$past(sys_rst) |->
    buck_freq_high == $past(frequency_range_strap))
    else $error("frequency range wrong");
  chk_pfm_sleep: assert property (
    buck_pfm_en |-> state == `WESC_ST_SLEEP)
    else $error("pfm outside sleep");
  chk_init_exit: assert property (
    $past(state) == `WESC_ST_INIT && state == `WESC_ST_NORMAL
    |-> $past(reg_wr) && $past(reg_addr) == `WESC_ADDR_CMD)
    else $error("init left without command");
  chk_quiet_hold: assert property (
    !$past(reg_wr) && $past(state)
    inside {`WESC_ST_INIT, `WESC_ST_NORMAL, `WESC_ST_WAKE}
    |-> $stable(state))
    else $error("state moved without cause");
  chk_sleep_exit: assert property (
    !$past(reg_wr) && $past(state) == `WESC_ST_SLEEP &&
    state != `WESC_ST_SLEEP |-> state == `WESC_ST_WAKE)
    else $error("sleep left wrongly");
  chk_stby_exit: assert property (
    !$past(reg_wr) && $past(state)
    inside {`WESC_ST_STANDBY, `WESC_ST_FAIL_SAFE_STATE} && $changed(state)
    |-> state == `WESC_ST_INIT)
    else $error("standby or fail-safe left wrongly");
  chk_div_reset: assert property (
    $past(state) == `WESC_ST_TO_STBY && state == `WESC_ST_INIT
    |-> reset_output)
    else $error("no reset on standby diversion");
  chk_div_irq: assert property (
    $past(state) == `WESC_ST_TO_SLEEP && state == `WESC_ST_WAKE
    |-> ##[0:1] irq)
    else $error("no interrupt on sleep diversion");
  cov_sleep_div: cover property ($past(state) == `WESC_ST_TO_SLEEP &&
    state == `WESC_ST_WAKE);
  cov_stby_div: cover property ($past(state) == `WESC_ST_TO_STBY &&
    state == `WESC_ST_INIT);
  cov_pfm: cover property (buck_pfm_en);
endmodule
bind wesc_ctrl wesc_ctrl_asserts i_wesc_ctrl_asserts (.clk_sys,
  .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .boost_select_strap,
  .frequency_range_strap, .input_uv, .reset_output, .irq, .boost_en,
  .buck_en, .buck_freq_high, .buck_pfm_en, .state);

// file: tb/wesc_host.sv
// Host model: issues commands and reads over the plain register port.
// Assumes the bench calls its tasks; one request at a time.
`timescale 1ns/1ps
module wesc_host (
  input  wire logic        clk_sys,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Commands go out only on request; one-cycle strobe
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule

// file: tb/wesc_ctrl_bench.sv
// Self-checking bench for wesc_ctrl with a host model.
// Assumes a shortened wake qualification count for run time.
`timescale 1ns/1ps
`include "wesc_map.vh"
module wesc_ctrl_bench;
  logic clk_sys = 0, sys_rst = 1, wk = 0, en = 0, bs = 1, fs = 1;
  logic uv = 0, ll = 0, rst_o, irq, boost_en, buck_en, fhi, pfm;
  logic [7:0] a;
  logic [31:0] wd, rdat, d;
  logic wr, rd;
  logic [2:0] state;
  integer n_fail = 0, checks_done = 0, seed = 44083, i;
  initial forever #5 clk_sys = ~clk_sys;
  wesc_host i_wesc_host (.clk_sys(clk_sys), .reg_addr(a),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat));
  wesc_ctrl #(.WAKE_MIN_CYC(20), .TRANS_CYC(16)) i_wesc_ctrl (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(a),
    .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat),
    .wake_level_input(wk), .enable_edge_input(en),
    .boost_select_strap(bs), .frequency_range_strap(fs),
    .input_uv(uv), .light_load(ll), .reset_output(rst_o), .irq(irq),
    .boost_en(boost_en), .buck_en(buck_en), .buck_freq_high(fhi),
    .buck_pfm_en(pfm), .state(state));
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] seen, exp, input string nm);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Bounded wait; a hang ends the run
  task wait_st(input logic [2:0] s);
    for (i = 0; i < 300 && state !== s; i++) @(posedge clk_sys);
    chk(state, s, "state");
    if (i == 300) test_done;
  endtask
  task cmd(input logic [2:0] c);
    i_wesc_host.wr(`WESC_ADDR_CMD, {29'h0, c});
  endtask
  // Rising enable edge; held high far past its minimum
  task en_rise;
    @(posedge clk_sys) en <= 1'b0;
    @(posedge clk_sys) en <= 1'b1;
  endtask
  task to_normal;
    cmd(`WESC_CMD_RST_DONE);
    cmd(`WESC_CMD_NORMAL);
    wait_st(`WESC_ST_NORMAL);
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1 chk(state, `WESC_ST_INIT, "init");
    chk(rst_o, 1'b1, "rst_out");
    // ************************************************************
    // Straps and undervoltage, random
    // ************************************************************
    repeat (16) begin
      @(posedge clk_sys);
      {bs, fs, uv} <= $random(seed);
      repeat (2) @(posedge clk_sys);
      #1 chk(boost_en, bs & uv, "boost_en");
      chk(fhi, fs, "freq_high");
      chk(buck_en, 1'b1, "buck_en");
    end
    i_wesc_host.wr(`WESC_ADDR_IRQ_EN, 32'hf);
    i_wesc_host.rd(8'h20, d);
    chk(d, 32'h0, "unmapped");
    i_wesc_host.rd(`WESC_ADDR_IRQ_EN, d);
    chk(d, 32'hf, "irq_en");
    i_wesc_host.rd(`WESC_ADDR_STATE, d);
    chk(d, {29'h0, `WESC_ST_INIT}, "state_reg");
    i_wesc_host.rd(`WESC_ADDR_STRAPS, d);
    chk(d, {28'h0, 1'b1, bs & uv, fs, bs}, "straps");
    to_normal;
    // ************************************************************
    // Sleep with enable high, short and long wake pulses
    // ************************************************************
    en <= 1'b1;
    ll <= 1'b1;
    // Let the enable edge pass in normal, where it is ignored
    repeat (8) @(posedge clk_sys);
    #1 chk(state, `WESC_ST_NORMAL, "en_normal");
    chk(pfm, 1'b0, "pfm_normal");
    cmd(`WESC_CMD_SLEEP);
    wait_st(`WESC_ST_SLEEP);
    @(posedge clk_sys) en <= 1'b0;
    @(posedge clk_sys) wk <= 1'b1;
    repeat (10) @(posedge clk_sys);
    wk <= 1'b0;
    repeat (40) @(posedge clk_sys);
    #1 chk(state, `WESC_ST_SLEEP, "short_wake");
    chk(pfm, 1'b1, "pfm");
    @(posedge clk_sys) wk <= 1'b1;
    wait_st(`WESC_ST_WAKE);
    wk <= 1'b0;
    #1 chk(pfm, 1'b0, "pfm_wake");
    repeat (3) @(posedge clk_sys);
    #1 chk(irq, 1'b1, "irq");
    i_wesc_host.rd(`WESC_ADDR_IRQ_STAT, d);
    chk(d[`WESC_IRQ_WAKE_EVT], 1'b1, "irq_stat");
    i_wesc_host.wr(`WESC_ADDR_IRQ_CLR, 32'hf);
    repeat (2) @(posedge clk_sys);
    #1 chk(irq, 1'b0, "irq_clear");
    // ************************************************************
    // Standby exit, diversions, fail-safe exit
    // ************************************************************
    cmd(`WESC_CMD_STANDBY);
    wait_st(`WESC_ST_STANDBY);
    en_rise;
    wait_st(`WESC_ST_INIT);
    to_normal;
    cmd(`WESC_CMD_SLEEP);
    en_rise;
    wait_st(`WESC_ST_WAKE);
    repeat (2) @(posedge clk_sys);
    #1 chk(irq, 1'b1, "div_irq");
    cmd(`WESC_CMD_STANDBY);
    en_rise;
    wait_st(`WESC_ST_INIT);
    #1 chk(rst_o, 1'b1, "div_rst");
    cmd(`WESC_CMD_FAIL_SAFE_STATE);
    wait_st(`WESC_ST_FAIL_SAFE_STATE);
    en_rise;
    wait_st(`WESC_ST_INIT);
    test_done;
  end
endmodule
